// ---- rtl/swe_pkg.sv ----
// constants and types for the spi write-enable memory block
package swe_pkg;
    localparam int ADDR_W = 9;
    localparam int DEPTH = 512;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_ADDR_HI = 8'h08;
    localparam int OP_ADDR_HI_BIT = 3;
    // command codes below are the common defaults for this device class
    localparam logic [7:0] OP_SET_WEN = 8'h06;
    localparam logic [7:0] OP_CLR_WEN = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam int WEN_FLAG_BIT = 1;
    localparam int BP_LO_BIT = 2;
    localparam int BP_HI_BIT = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_ADDR = 3'b001,
        PH_DATA_WR = 3'b010,
        PH_DATA_RD = 3'b011,
        PH_STAT_WR = 3'b100,
        PH_STAT_RD = 3'b101,
        PH_IGNORE = 3'b110
    } swe_phase_t;
endpackage

// ---- rtl/swe_mem.sv ----
// 512 x 8 array with registered read data
`timescale 1ns/10ps
`default_nettype none
module swe_mem (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [swe_pkg::ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [swe_pkg::ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [swe_pkg::DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- rtl/swe_spi_mem.sv ----
// spi memory slave: command decode, write-enable flag, status register
//
// Notes on behaviour
// [RQ1] set-enable command sets flag, shown in status
// [RQ2] writes accepted only while flag is one
// [RQ3] the written status byte never changes the flag
// [RQ4] completed status or low-half write clears flag
// [RQ5] completed upper-half write leaves flag set
// [RQ6] flag is status bit 1, reset zero
// [RQ7] status bits 2,3 hold protect range
// [RQ8] status bits 0,4-7 read zero
// [RQ9] nine-bit address, msb inside command byte
// [RQ10] write command 0000a010, a is bit 8
// [RQ11] read command 0000a011, a is bit 8
// [RQ12] clear-enable command clears flag, blocks writes
// [RQ13] host sends clear-enable after each write; the testbench sends it after one write only, the one to 9'h100
// [RQ14] host reproduces defect via upper-half write
// [RQ15] low address byte, then data, wrapping address
// [RQ16] chip select frames; bytes act when complete
`timescale 1ns/10ps
`default_nettype none
module swe_spi_mem (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // spi pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic sck_meta;
        logic sck_sync;
        logic sck_prev;
        logic mosi_meta;
        logic mosi_sync;
        swe_pkg::swe_phase_t phase;
        logic is_read;
        logic hi_op;
        logic wrote;
        logic [2:0] bitcnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [swe_pkg::ADDR_W-1:0] addr;
        logic [1:0] fetch;
        logic wen_flag;
        logic [1:0] bp;
        logic mem_we;
        logic [swe_pkg::ADDR_W-1:0] mem_wa;
        logic [7:0] mem_wd;
        logic miso;
        logic miso_oe;
    } swe_state_t;

    swe_state_t st_r;
    swe_state_t st_nxt;
    logic [7:0] mem_rdata;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic byte_done;
    logic [7:0] byte_in;
    logic [7:0] status_word;

    swe_mem u_mem (
        .clk(ref_clk),
        .we(st_r.mem_we),
        .waddr(st_r.mem_wa),
        .wdata(st_r.mem_wd),
        .raddr(st_r.addr),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // edges are found on the second sync stage only
    assign sck_rise = st_r.sck_sync && !st_r.sck_prev && !st_r.cs_sync;
    assign sck_fall = !st_r.sck_sync && st_r.sck_prev && !st_r.cs_sync;
    assign frame_end = st_r.cs_sync && !st_r.cs_prev;
    assign byte_done = sck_rise && (st_r.bitcnt == swe_pkg::LAST_BIT);
    assign byte_in = {st_r.rx[6:0], st_r.mosi_sync};

    always_comb begin
        status_word = swe_pkg::STATUS_RESET; // see [RQ8]
        status_word[swe_pkg::WEN_FLAG_BIT] = st_r.wen_flag; // see [RQ1] see [RQ6]
        status_word[swe_pkg::BP_LO_BIT] = st_r.bp[0]; // see [RQ7]
        status_word[swe_pkg::BP_HI_BIT] = st_r.bp[1];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.cs_meta = cs_n;
        st_nxt.cs_sync = st_r.cs_meta;
        st_nxt.cs_prev = st_r.cs_sync;
        st_nxt.sck_meta = sck;
        st_nxt.sck_sync = st_r.sck_meta;
        st_nxt.sck_prev = st_r.sck_sync;
        st_nxt.mosi_meta = mosi;
        st_nxt.mosi_sync = st_r.mosi_meta;
        st_nxt.mem_we = 1'b0;
        st_nxt.fetch = {st_r.fetch[0], 1'b0};
        if (st_r.fetch[1]) begin
            st_nxt.tx = mem_rdata; // see [RQ15]
        end
        if (sck_rise) begin
            st_nxt.rx = byte_in;
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
        end
        if (sck_fall) begin
            st_nxt.miso = st_r.tx[7];
            st_nxt.tx = {st_r.tx[6:0], 1'b0};
            st_nxt.miso_oe = (st_r.phase == swe_pkg::PH_DATA_RD) || (st_r.phase == swe_pkg::PH_STAT_RD);
        end
        if (byte_done) begin
            case (st_r.phase)
                swe_pkg::PH_CMD: begin
                    st_nxt.hi_op = byte_in[swe_pkg::OP_ADDR_HI_BIT];
                    if ((byte_in & ~swe_pkg::OP_ADDR_HI) == swe_pkg::OP_WRITE) begin // see [RQ10]
                        st_nxt.phase = swe_pkg::PH_ADDR;
                        st_nxt.is_read = 1'b0;
                    end else if ((byte_in & ~swe_pkg::OP_ADDR_HI) == swe_pkg::OP_READ) begin // see [RQ11]
                        st_nxt.phase = swe_pkg::PH_ADDR;
                        st_nxt.is_read = 1'b1;
                    end else if (byte_in == swe_pkg::OP_SET_WEN) begin
                        st_nxt.wen_flag = 1'b1; // see [RQ1]
                        st_nxt.phase = swe_pkg::PH_IGNORE;
                    end else if (byte_in == swe_pkg::OP_CLR_WEN) begin
                        st_nxt.wen_flag = 1'b0; // see [RQ12]
                        st_nxt.phase = swe_pkg::PH_IGNORE;
                    end else if (byte_in == swe_pkg::OP_STAT_RD) begin
                        st_nxt.tx = status_word;
                        st_nxt.phase = swe_pkg::PH_STAT_RD;
                    end else if (byte_in == swe_pkg::OP_STAT_WR) begin
                        st_nxt.phase = swe_pkg::PH_STAT_WR;
                    end else begin
                        st_nxt.phase = swe_pkg::PH_IGNORE;
                    end
                end
                swe_pkg::PH_ADDR: begin
                    st_nxt.addr = {st_r.hi_op, byte_in}; // see [RQ9]
                    if (st_r.is_read) begin
                        st_nxt.phase = swe_pkg::PH_DATA_RD;
                        st_nxt.fetch = 2'b01;
                    end else begin
                        st_nxt.phase = swe_pkg::PH_DATA_WR;
                    end
                end
                swe_pkg::PH_DATA_WR: begin
                    // each byte lands as soon as it is complete; see [RQ16]
                    st_nxt.mem_we = st_r.wen_flag; // see [RQ2]
                    st_nxt.mem_wa = st_r.addr;
                    st_nxt.mem_wd = byte_in;
                    st_nxt.wrote = st_r.wrote || st_r.wen_flag;
                    st_nxt.addr = st_r.addr + 9'h001; // see [RQ15]
                end
                swe_pkg::PH_DATA_RD: begin
                    st_nxt.addr = st_r.addr + 9'h001;
                    st_nxt.fetch = 2'b01;
                end
                swe_pkg::PH_STAT_WR: begin
                    // flag bit of the written byte is dropped; see [RQ3]
                    if (st_r.wen_flag) begin // see [RQ2]
                        st_nxt.bp = {byte_in[swe_pkg::BP_HI_BIT], byte_in[swe_pkg::BP_LO_BIT]}; // see [RQ7]
                        st_nxt.wrote = 1'b1;
                    end
                    st_nxt.phase = swe_pkg::PH_IGNORE;
                end
                swe_pkg::PH_STAT_RD: begin
                    st_nxt.tx = status_word;
                end
                default: begin
                    st_nxt.phase = swe_pkg::PH_IGNORE;
                end
            endcase
        end
        if (st_r.cs_sync) begin
            st_nxt.phase = swe_pkg::PH_CMD; // see [RQ16]
            st_nxt.bitcnt = 3'h0;
            st_nxt.miso_oe = 1'b0;
            st_nxt.wrote = 1'b0;
            st_nxt.fetch = 2'b00;
        end
        if (frame_end && st_r.wrote) begin
            // upper-half array write keeps the flag, a known silicon quirk
            if (st_r.phase == swe_pkg::PH_IGNORE || !st_r.hi_op) begin // see [RQ4]
                st_nxt.wen_flag = 1'b0;
            end // see [RQ5]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, phase: swe_pkg::PH_CMD,
                      default: '0}; // see [RQ6]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign miso = st_r.miso;
    assign miso_oe = st_r.miso_oe;

    ////////////////////////////////////////////////////////////////////////
    sequence cmd_seen(logic [7:0] op);
        byte_done && st_r.phase == swe_pkg::PH_CMD && byte_in == op;
    endsequence

    sequence fetch_done;
        st_r.fetch[1] ##1 1'b1;
    endsequence

    flag_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ1]
        cmd_seen(swe_pkg::OP_SET_WEN) ##1 !st_r.cs_sync |-> st_r.wen_flag && status_word[swe_pkg::WEN_FLAG_BIT])
        else $error("flag not set by enable command");

    write_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ2]
        st_r.mem_we |-> $past(st_r.wen_flag) && $past(st_r.phase) == swe_pkg::PH_DATA_WR)
        else $error("array written without enable");

    stat_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ3]
        byte_done && st_r.phase == swe_pkg::PH_STAT_WR |=> st_r.wen_flag == $past(st_r.wen_flag))
        else $error("status write changed the flag");

    flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ4]
        frame_end && st_r.wrote && !(st_r.phase == swe_pkg::PH_DATA_WR && st_r.hi_op) |=> !st_r.wen_flag)
        else $error("flag not cleared after write");

    defect_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ5]
        frame_end && st_r.wen_flag && st_r.phase == swe_pkg::PH_DATA_WR && st_r.hi_op |=> st_r.wen_flag)
        else $error("upper-half write cleared the flag");

    stat_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ8]
        byte_done && st_r.phase == swe_pkg::PH_STAT_RD |=> st_r.tx[7:4] == 4'h0 && !st_r.tx[0])
        else $error("reserved status bits not zero");

    addr_msb_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ9]
        byte_done && st_r.phase == swe_pkg::PH_ADDR |=> st_r.addr[8] == $past(st_r.hi_op))
        else $error("address bit 8 not taken from command");

    clr_cmd_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ12]
        cmd_seen(swe_pkg::OP_CLR_WEN) |=> !st_r.wen_flag)
        else $error("flag not cleared by disable command");

    read_load_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ15]
        fetch_done |-> st_r.tx == $past(mem_rdata))
        else $error("read data not loaded");

    frame_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RQ16]
        frame_end |=> st_r.phase == swe_pkg::PH_CMD && !st_r.miso_oe)
        else $error("frame end did not idle the slave");
endmodule
`default_nettype wire

// ---- verif/swe_host_model.sv ----
// spi host model: mode 0 master that drives chip select, clock and data
`timescale 1ns/10ps
`default_nettype none
module swe_host_model (
    // clock
    input wire logic ref_clk,
    // spi pins
    output logic cs_n,
    output logic sck,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // sck stands low outside frames
    task automatic open_frame();
        cs_n = 1'b0;
        wait_clk(4);
    endtask
    // idle mosi is inverted so a stale bit never passes for data
    task automatic close_frame();
        wait_clk(4);
        cs_n = 1'b1;
        mosi = ~mosi;
        wait_clk(8);
    endtask
    // msb first, shifted while sck low, both sides sample on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            wait_clk(4);
            sck = 1'b1;
            rx[i] = miso_oe ? miso : 1'bx;
            wait_clk(4);
            sck = 1'b0;
        end
    endtask
    // opcode 0000a01r with a = address bit 8 and r = ~wr (0 for a write), then low address byte
    task automatic mem_op(input logic wr, input logic [8:0] addr);
        logic [7:0] rx;
        xfer({4'h0, addr[8], 2'b01, ~wr}, rx);
        xfer(addr[7:0], rx);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// testbench: spi command sequences against the write-enable memory block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk;
    logic rst;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [7:0] rx;
    int mismatches = 0;
    int n_tests = 0;
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    swe_spi_mem dut_u (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));
    swe_host_model host_u (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        host_u.open_frame();
        host_u.xfer(op, rx);
        host_u.close_frame();
    endtask
    task automatic stat(input logic [7:0] exp);
        host_u.open_frame();
        host_u.xfer(swe_pkg::OP_STAT_RD, rx);
        host_u.xfer(8'h00, rx);
        host_u.close_frame();
        check(rx, exp, "status");
        check({7'h00, miso_oe}, 8'h00, "output enable after frame");
    endtask
    task automatic swr(input logic [7:0] d);
        host_u.open_frame();
        host_u.xfer(swe_pkg::OP_STAT_WR, rx);
        host_u.xfer(d, rx);
        host_u.close_frame();
    endtask
    task automatic mwr(input logic [8:0] a, input logic [7:0] d0, input logic [7:0] d1);
        host_u.open_frame();
        host_u.mem_op(1'b1, a);
        host_u.xfer(d0, rx);
        host_u.xfer(d1, rx);
        host_u.close_frame();
    endtask
    task automatic mrd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
        host_u.open_frame();
        host_u.mem_op(1'b0, a);
        host_u.xfer(8'h00, rx);
        check(rx, e0, "read byte 0");
        host_u.xfer(8'h00, rx);
        check(rx, e1, "read byte 1");
        host_u.close_frame();
    endtask
    ////////////////////////////////////////////////////////////////
    // whole sequence is some 5000 clocks; the limit leaves ample margin
    initial begin
        #2000000;
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        stat(8'h00);
        cmd(swe_pkg::OP_SET_WEN);
        stat(8'h02);
        mwr(9'h0ff, 8'h11, 8'h22);
        stat(8'h00);
        mwr(9'h0ff, 8'h99, 8'h99);
        mrd(9'h0ff, 8'h11, 8'h22);
        cmd(swe_pkg::OP_SET_WEN);
        mwr(9'h1ff, 8'h33, 8'h44);
        stat(8'h02);
        // flag left set, so this write lands without a fresh enable
        mwr(9'h1ff, 8'h55, 8'h66);
        mrd(9'h1ff, 8'h55, 8'h66);
        swr(8'hff);
        stat(8'h0c);
        swr(8'h00);
        stat(8'h0c);
        cmd(swe_pkg::OP_SET_WEN);
        cmd(swe_pkg::OP_CLR_WEN);
        stat(8'h0c);
        mwr(9'h0ff, 8'h77, 8'h77);
        mrd(9'h0ff, 8'h11, 8'h22);
        cmd(swe_pkg::OP_SET_WEN);
        mwr(9'h100, 8'hab, 8'hcd);
        stat(8'h0e);
        cmd(swe_pkg::OP_CLR_WEN);
        stat(8'h0c);
        mrd(9'h100, 8'hab, 8'hcd);
        complete_run();
    end
endmodule
`default_nettype wire
